// ---- rtl/pdc_pkg.sv ----
// Constants shared by the packet line coder and its event router
package pdc_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_PAYLOAD_CFG = 4'h0;
  localparam logic [3:0] OFS_PACKET_CFG  = 4'h1;
  localparam logic [3:0] OFS_RATE_CFG    = 4'h2;
  localparam logic [3:0] OFS_EVENT_ROUTE = 4'h3;
  localparam logic [3:0] OFS_MODE        = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS  = 4'h5;
  localparam logic [3:0] OFS_IRQ_ENABLE  = 4'h6;
  localparam logic [3:0] OFS_IRQ_CLEAR   = 4'h7;
  localparam logic [3:0] OFS_LINE_STATUS = 4'h8;

  // Field positions
  localparam int POS_MAN_EN     = 7;
  localparam int POS_WHITE_EN   = 4;
  localparam int POS_ADDR_FIL   = 1;
  localparam int POS_L0_RX_SEL  = 0;
  localparam int POS_L1_RX_SEL  = 2;
  localparam int POS_L1_TX_SEL  = 4;
  localparam int POS_TX_START   = 5;
  localparam int POS_CHIP_MODE  = 0;
  localparam int POS_PKT_MODE   = 2;

  // Reset values
  localparam logic [7:0] RST_PAYLOAD_CFG = 8'h00;
  localparam logic [7:0] RST_PACKET_CFG  = 8'h00;
  localparam logic [6:0] RST_RATE        = 7'h07;
  localparam logic [5:0] RST_ROUTE       = 6'h00;
  localparam logic [2:0] RST_MODE        = 3'h4;
  localparam logic [3:0] RST_IRQ         = 4'h0;

  // Chip modes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_RX      = 2'h1;
  localparam logic [1:0] MODE_TX      = 2'h2;

  // Event source codes for the two event lines
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;

  // Interrupt status bit positions
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_DECERR = 1;
  localparam int IRQ_SENT = 2;
  localparam int IRQ_PAYLOAD = 3;
  localparam int IRQ_N = 4;

  // Whitening generator
  localparam int          LFSR_W    = 9;
  localparam int          LFSR_TAP  = 4;
  localparam logic [8:0]  LFSR_SEED = 9'h1FF;

  // Transmit chip sequencer states
  typedef enum logic [1:0] {
    TXS_DATA = 2'b01,
    TXS_HALF = 2'b10
  } pdc_tx_e;

endpackage

// ---- rtl/pdc_lfsr.sv ----
// Nine-bit whitening sequence generator, x^9 + x^5 + 1
`timescale 1ns/100ps
module pdc_lfsr
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // Control
  input  wire logic load_i,
  input  wire logic step_i,
  // Sequence bit
  output logic      bit_o
);

  logic [LFSR_W-1:0] state;
  logic              feedback;

  // Taps at x^9 and x^5
  assign feedback = state[LFSR_W-1] ^ state[LFSR_TAP];
  assign bit_o    = state[LFSR_W-1];

  // Seed held while outside the payload, so each payload starts fresh
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= LFSR_SEED;
    end else if (load_i) begin
      state <= LFSR_SEED;
    end else if (step_i) begin
      state <= {state[LFSR_W-2:0], feedback};
    end
  end

  chk_lfsr_seed: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    load_i |=> state == LFSR_SEED)
    else $error("whitening generator not seeded");

  chk_lfsr_step: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (!load_i && step_i) |=> state == {$past(state[LFSR_W-2:0]), $past(feedback)})
    else $error("whitening generator did not advance");

endmodule

// ---- rtl/pdc_codec.sv ----
// Packet line coder: Manchester, whitening and event line routing
`timescale 1ns/100ps
module pdc_codec
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Transmit bits from packet handler
  input  wire logic              tx_bit_i,
  input  wire logic              tx_bit_valid_i,
  input  wire logic              tx_payload_i,
  output logic                   tx_bit_ready_o,
  // Transmit chips to modulator
  output logic                   chip_o,
  output logic                   chip_valid_o,
  // Receive chips from demodulator
  input  wire logic              rx_chip_i,
  input  wire logic              rx_chip_valid_i,
  input  wire logic              rx_frame_end_i,
  // Receive bits to packet handler
  output logic                   rx_bit_o,
  output logic                   rx_bit_valid_o,
  // Packet handler events
  input  wire logic              payload_complete_i,
  input  wire logic              byte_written_i,
  input  wire logic              fifo_empty_i,
  input  wire logic              sync_detect_i,
  input  wire logic              addr_match_i,
  input  wire logic              checksum_pass_i,
  input  wire logic              fifo_full_i,
  input  wire logic              signal_strength_i,
  input  wire logic              level_threshold_i,
  input  wire logic              fifo_threshold_i,
  input  wire logic              send_complete_i,
  // Event lines and interrupt
  output logic                   event_line_a_o,
  output logic                   event_line_b_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]       payload_config_reg;
  logic [7:0]       packet_config_reg;
  logic [6:0]       rate_config_reg;
  logic [5:0]       event_route_reg;
  logic [2:0]       mode_reg;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;
  logic [IRQ_N-1:0] irq_set;
  logic             in_payload;

  // Field decode
  wire       manchester_enable   = payload_config_reg[POS_MAN_EN];
  wire       whitening_enable    = packet_config_reg[POS_WHITE_EN];
  wire       addr_filter_on      = |packet_config_reg[POS_ADDR_FIL +: 2];
  wire [1:0] line0_rx_source_sel = event_route_reg[POS_L0_RX_SEL +: 2];
  wire [1:0] line1_rx_source_sel = event_route_reg[POS_L1_RX_SEL +: 2];
  wire       line1_tx_select     = event_route_reg[POS_L1_TX_SEL];
  wire       tx_start_select     = event_route_reg[POS_TX_START];
  wire [1:0] chip_mode           = mode_reg[POS_CHIP_MODE +: 2];
  wire       packet_mode         = mode_reg[POS_PKT_MODE];
  wire       mode_rx             = chip_mode == MODE_RX;
  wire       mode_tx             = chip_mode == MODE_TX;
  wire       mode_sb             = chip_mode == MODE_STANDBY;

  // Write decode
  wire wr_payload = reg_wr_i && reg_addr_i == OFS_PAYLOAD_CFG;
  wire wr_packet  = reg_wr_i && reg_addr_i == OFS_PACKET_CFG;
  wire wr_rate    = reg_wr_i && reg_addr_i == OFS_RATE_CFG;
  wire wr_route   = reg_wr_i && reg_addr_i == OFS_EVENT_ROUTE;
  wire wr_mode    = reg_wr_i && reg_addr_i == OFS_MODE;
  wire wr_enable  = reg_wr_i && reg_addr_i == OFS_IRQ_ENABLE;
  wire wr_clear   = reg_wr_i && reg_addr_i == OFS_IRQ_CLEAR;

  // Configuration writes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      payload_config_reg <= RST_PAYLOAD_CFG;
      packet_config_reg  <= RST_PACKET_CFG;
      rate_config_reg    <= RST_RATE;
      event_route_reg    <= RST_ROUTE;
      mode_reg           <= RST_MODE;
      irq_enable         <= RST_IRQ;
    end else begin
      if (wr_payload) payload_config_reg <= reg_wdata_i;
      if (wr_packet)  packet_config_reg  <= reg_wdata_i;
      if (wr_rate)    rate_config_reg    <= reg_wdata_i[6:0];
      if (wr_route)   event_route_reg    <= reg_wdata_i[5:0];
      if (wr_mode)    mode_reg           <= reg_wdata_i[2:0];
      if (wr_enable)  irq_enable         <= reg_wdata_i[IRQ_N-1:0];
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  wire [IRQ_N-1:0] irq_clr = wr_clear ? reg_wdata_i[IRQ_N-1:0] : '0;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  // Read mux; clear register and unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_i)
      OFS_PAYLOAD_CFG: rd_mux = payload_config_reg;
      OFS_PACKET_CFG:  rd_mux = packet_config_reg;
      OFS_RATE_CFG:    rd_mux = {1'b0, rate_config_reg};
      OFS_EVENT_ROUTE: rd_mux = {2'b00, event_route_reg};
      OFS_MODE:        rd_mux = {5'h00, mode_reg};
      OFS_IRQ_STATUS:  rd_mux = {4'h0, irq_status};
      OFS_IRQ_ENABLE:  rd_mux = {4'h0, irq_enable};
      OFS_LINE_STATUS: rd_mux = {5'h00, in_payload, event_line_b_o, event_line_a_o};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip rate divider, shared by every part of the frame

  logic [6:0] rate_cnt;
  wire        tick = rate_cnt == 7'h00;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_cnt <= 7'h00;
    end else begin
      rate_cnt <= tick ? rate_config_reg : rate_cnt - 7'h01;
    end
  end

  chk_chip_rate_gap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tick && rate_config_reg != 7'h00) |=> !tick)
    else $error("chip ticks closer than the rate allows");

  ////////////////////////////////////////////////////////////////////////////
  // Transmit coder

  pdc_tx_e tx_st;
  logic    tx_second;
  logic    tx_white_bit;

  // Coding applies only inside payload and CRC; Manchester only in packet mode, whitening in any mode
  wire man_tx_act = manchester_enable && packet_mode && tx_payload_i;
  wire wh_tx_act  = whitening_enable && tx_payload_i;
  wire tx_take    = tick && tx_st == TXS_DATA && tx_bit_valid_i;
  wire tx_coded   = tx_bit_i ^ (wh_tx_act & tx_white_bit);

  assign tx_bit_ready_o = tick && tx_st == TXS_DATA;

  // Manchester bits span two ticks, whitened or plain bits one
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_st        <= TXS_DATA;
      tx_second    <= 1'b0;
      chip_o       <= 1'b0;
      chip_valid_o <= 1'b0;
    end else begin
      chip_valid_o <= 1'b0;
      unique case (tx_st)
        TXS_DATA: begin
          if (tx_take) begin
            chip_o       <= tx_coded;
            chip_valid_o <= 1'b1;
            tx_second    <= ~tx_coded;
            if (man_tx_act) tx_st <= TXS_HALF;
          end
        end
        TXS_HALF: begin
          if (tick) begin
            chip_o       <= tx_second;
            chip_valid_o <= 1'b1;
            tx_st        <= TXS_DATA;
          end
        end
      endcase
    end
  end

  pdc_lfsr u_tx_white (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .load_i    (!tx_payload_i),
    .step_i    (tx_take && wh_tx_act),
    .bit_o     (tx_white_bit)
  );

  // Helper: chip level at the previous emitted chip
  logic prev_chip;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_chip <= 1'b0;
    end else if (chip_valid_o) begin
      prev_chip <= chip_o;
    end
  end

  sequence s_second_chip;
    chip_valid_o && $past(tx_st) == TXS_HALF;
  endsequence

  chk_man_pair_inv: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    s_second_chip |-> chip_o != prev_chip)
    else $error("second Manchester chip equals the first");

  chk_white_xor: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tx_take && wh_tx_act) |=> chip_valid_o && chip_o == ($past(tx_bit_i) ^ $past(tx_white_bit)))
    else $error("payload chip not whitened");

  chk_nrz_header: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tx_take && !tx_payload_i) |=> chip_o == $past(tx_bit_i) && tx_st == TXS_DATA)
    else $error("header bit was coded");

  chk_white_rate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tx_take && !man_tx_act) |=> chip_valid_o && tx_st == TXS_DATA)
    else $error("plain bit used more than one chip");

  ////////////////////////////////////////////////////////////////////////////
  // Receive decoder; bits pass only after sync, so unsynced frames vanish

  logic rx_have_first;
  logic rx_first;
  logic rx_white_bit;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_payload <= 1'b0;
    end else if (sync_detect_i && mode_rx) begin
      in_payload <= 1'b1;
    end else if (rx_frame_end_i) begin
      in_payload <= 1'b0;
    end
  end

  wire man_rx_act = manchester_enable && packet_mode && in_payload;
  wire wh_rx_act  = whitening_enable && in_payload;
  wire rx_acc     = rx_chip_valid_i && in_payload;
  wire rx_fire    = rx_acc && (!man_rx_act || rx_have_first);
  wire rx_raw     = man_rx_act ? rx_first : rx_chip_i;
  wire rx_decerr  = rx_acc && man_rx_act && rx_have_first && rx_first == rx_chip_i;

  // First chip of a pair is held, the pair yields one NRZ bit
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_have_first  <= 1'b0;
      rx_first       <= 1'b0;
      rx_bit_o       <= 1'b0;
      rx_bit_valid_o <= 1'b0;
    end else begin
      rx_bit_valid_o <= rx_fire;
      if (rx_fire) rx_bit_o <= rx_raw ^ (wh_rx_act & rx_white_bit);
      if (!in_payload) begin
        rx_have_first <= 1'b0;
      end else if (rx_acc && man_rx_act) begin
        rx_have_first <= !rx_have_first;
        if (!rx_have_first) rx_first <= rx_chip_i;
      end
    end
  end

  pdc_lfsr u_rx_white (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .load_i    (!in_payload),
    .step_i    (rx_fire && wh_rx_act),
    .bit_o     (rx_white_bit)
  );

  sequence s_rx_second;
    rx_acc && man_rx_act && rx_have_first && !wh_rx_act;
  endsequence

  chk_rx_decode: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    s_rx_second |=> rx_bit_valid_o && rx_bit_o == $past(rx_first))
    else $error("Manchester pair decoded wrongly");

  chk_rx_drop: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !in_payload |=> !rx_bit_valid_o)
    else $error("bit delivered without sync");

  ////////////////////////////////////////////////////////////////////////////
  // Event holding and line routing

  logic pl_hold;
  logic crc_hold;
  logic addr_hold;
  logic sync_hold;

  // Held until the FIFO reads empty; a new event wins over the clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pl_hold   <= 1'b0;
      crc_hold  <= 1'b0;
      addr_hold <= 1'b0;
      sync_hold <= 1'b0;
    end else begin
      pl_hold   <= payload_complete_i | (pl_hold & !fifo_empty_i);
      crc_hold  <= checksum_pass_i | (crc_hold & !fifo_empty_i);
      addr_hold <= addr_match_i | (addr_hold & !fifo_empty_i);
      sync_hold <= sync_detect_i | (sync_hold & !fifo_empty_i);
    end
  end

  wire match_ev = addr_filter_on ? addr_hold : sync_hold;

  // Line A and line B sources per mode and code
  logic rx_a;
  logic rx_b;
  always_comb begin
    rx_a = 1'b0;
    rx_b = 1'b0;
    unique case (line0_rx_source_sel)
      SEL_00: rx_a = pl_hold;
      SEL_01: rx_a = byte_written_i;
      SEL_10: rx_a = fifo_empty_i;
      SEL_11: rx_a = match_ev;
    endcase
    unique case (line1_rx_source_sel)
      SEL_00: rx_b = crc_hold;
      SEL_01: rx_b = fifo_full_i;
      SEL_10: rx_b = signal_strength_i;
      SEL_11: rx_b = level_threshold_i;
    endcase
  end

  wire sb_a = line0_rx_source_sel == SEL_10 && fifo_empty_i;
  wire sb_b = (line1_rx_source_sel == SEL_01 && fifo_full_i) ||
              (line1_rx_source_sel == SEL_11 && level_threshold_i);
  wire tx_a = tx_start_select ? fifo_empty_i : fifo_threshold_i;
  wire tx_b = line1_tx_select ? send_complete_i : fifo_full_i;

  wire next_line_a = (mode_rx & rx_a) | (mode_sb & sb_a) | (mode_tx & tx_a);
  wire next_line_b = (mode_rx & rx_b) | (mode_sb & sb_b) | (mode_tx & tx_b);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_line_a_o <= 1'b0;
      event_line_b_o <= 1'b0;
    end else begin
      event_line_a_o <= next_line_a;
      event_line_b_o <= next_line_b;
    end
  end

  // Interrupt event sources
  assign irq_set[IRQ_SYNC]    = sync_detect_i && mode_rx;
  assign irq_set[IRQ_DECERR]  = rx_decerr;
  assign irq_set[IRQ_SENT]    = send_complete_i;
  assign irq_set[IRQ_PAYLOAD] = payload_complete_i;

  chk_line_a_ready: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (mode_rx && line0_rx_source_sel == SEL_00) |=> event_line_a_o == $past(pl_hold))
    else $error("line A not carrying payload complete");

  chk_standby_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (mode_sb && line0_rx_source_sel != SEL_10) |=> !event_line_a_o)
    else $error("line A driven in standby");

  chk_standby_b: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (mode_sb && line1_rx_source_sel[0] == 1'b0) |=> !event_line_b_o)
    else $error("line B driven in standby by a receive code");

  chk_tx_line_b: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    mode_tx |=> event_line_b_o == $past(line1_tx_select ? send_complete_i : fifo_full_i))
    else $error("line B wrong in transmit");

  chk_match_sel: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (mode_rx && line0_rx_source_sel == SEL_11 && !addr_filter_on) |=> event_line_a_o == $past(sync_hold))
    else $error("match line not following sync");

  chk_hold_ready: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (pl_hold && !fifo_empty_i) |=> pl_hold [*1] ##0 $stable(pl_hold))
    else $error("payload complete dropped before FIFO empty");

endmodule

// ---- tb/pdc_demod_model.sv ----
// Demodulator stand-in that feeds received chips to the coder
`timescale 1ns/100ps
module pdc_demod_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Frame request
  input  wire logic        load_i,
  input  wire logic [15:0] chips_i,
  input  wire logic [4:0]  count_i,
  // Chips towards the coder
  output logic             chip_o,
  output logic             chip_valid_o,
  output logic             busy_o
);
  logic [15:0] shreg;
  logic [4:0]  left;
  logic        phase;

  // One chip every other cycle, msb first
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shreg        <= 16'h0000;
      left         <= 5'h00;
      phase        <= 1'b0;
      chip_o       <= 1'b0;
      chip_valid_o <= 1'b0;
    end else if (load_i) begin
      shreg        <= chips_i;
      left         <= count_i;
      phase        <= 1'b0;
      chip_valid_o <= 1'b0;
    end else begin
      phase        <= ~phase;
      chip_valid_o <= 1'b0;
      if (left != 5'h00 && phase) begin
        chip_o       <= shreg[15];
        chip_valid_o <= 1'b1;
        shreg        <= {shreg[14:0], 1'b0};
        left         <= left - 5'h01;
      end else if (left == 5'h00) begin
        chip_o <= ~chip_o;  // Idle line never keeps the last chip
      end
    end
  end

  assign busy_o = (left != 5'h00);
endmodule

// ---- tb/pdc_codec_bench.sv ----
// Self-checking bench for the packet line coder and event router
`timescale 1ns/100ps
module pdc_codec_bench
  import pdc_pkg::*;
;
  logic        clock = 1'b0, reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, d;
  logic        wr = 1'b0, rd = 1'b0, txb = 1'b0, txv = 1'b0, txp = 1'b0, fend = 1'b0, load = 1'b0;
  logic [10:0] src = 11'h000;
  logic [15:0] pat = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic [11:0] got;
  wire  [7:0]  rdata;
  wire         ready, chip, chipv, rxc, rxcv, rxb, rxbv, ea, eb, irq;
  int          failures = 0, n_tests = 0, cyc = 0;
  logic        chips[$], rbits[$];
  int          ctime[$];

  initial forever #2 clock = ~clock;

  pdc_codec dut_u (.clock_i(clock), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_bit_i(txb), .tx_bit_valid_i(txv),
    .tx_payload_i(txp), .tx_bit_ready_o(ready), .chip_o(chip), .chip_valid_o(chipv),
    .rx_chip_i(rxc), .rx_chip_valid_i(rxcv), .rx_frame_end_i(fend), .rx_bit_o(rxb),
    .rx_bit_valid_o(rxbv), .payload_complete_i(src[0]), .byte_written_i(src[1]),
    .fifo_empty_i(src[2]), .sync_detect_i(src[3]), .addr_match_i(src[4]), .checksum_pass_i(src[5]),
    .fifo_full_i(src[6]), .signal_strength_i(src[7]), .level_threshold_i(src[8]),
    .fifo_threshold_i(src[9]), .send_complete_i(src[10]), .event_line_a_o(ea),
    .event_line_b_o(eb), .irq_o(irq));

  pdc_demod_model air_u (.clock_i(clock), .reset_n_i(reset_n), .load_i(load), .chips_i(pat),
    .count_i(cnt), .chip_o(rxc), .chip_valid_o(rxcv), .busy_o());

  // Chip and bit collectors
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (chipv) begin
      chips.push_back(chip);
      ctime.push_back(cyc);
    end
    if (rxbv) rbits.push_back(rxb);
  end

  task automatic chk(input logic [15:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clock) wr <= 1'b0;
  endtask

  // Data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock) begin addr <= a; rd <= 1'b1; end
    @(posedge clock) rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Bit held until ready is seen, then released on the taking edge
  task automatic send_bit(input logic b, pl);
    int k;
    @(posedge clock) begin txb <= b; txp <= pl; txv <= 1'b1; end
    for (k = 0; k < 40; k++) begin
      @(negedge clock);
      if (ready === 1'b1) break;
    end
    @(posedge clock) txv <= 1'b0;
  endtask

  task automatic pulse_src(input logic [10:0] m);
    @(posedge clock) src <= m;
    @(posedge clock) src <= 11'h000;
  endtask

  task automatic feed(input logic [15:0] p, input logic [4:0] n);
    @(posedge clock) begin pat <= p; cnt <= n; load <= 1'b1; end
    @(posedge clock) load <= 1'b0;
    repeat (2 * n + 4) @(posedge clock);
  endtask

  function automatic logic [11:0] wseq();
    logic [8:0] s;
    int         i;
    s = LFSR_SEED;
    for (i = 11; i >= 0; i--) begin
      wseq[i] = s[8];
      s = {s[7:0], s[8] ^ s[LFSR_TAP]};
    end
  endfunction

  task automatic t_regs();
    logic [7:0] tab [10];
    int         i;
    tab = '{RST_PAYLOAD_CFG, RST_PACKET_CFG, {1'b0, RST_RATE}, {2'b00, RST_ROUTE}, {5'h00, RST_MODE},
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 10; i++) begin
      rd_reg(4'(i));
      chk(d, tab[i], "reset value");
    end
    wr_reg(4'h9, 8'hA5);
    wr_reg(OFS_IRQ_STATUS, 8'hFF);
    rd_reg(4'h9);
    chk(d, 8'h00, "unmapped read");
    rd_reg(OFS_IRQ_STATUS);
    chk(d, 8'h00, "status is read-only");
    $display("registers done");
  endtask

  task automatic t_tx_man();
    wr_reg(OFS_RATE_CFG, 8'h03);
    wr_reg(OFS_PAYLOAD_CFG, 8'h80);
    wr_reg(OFS_MODE, 8'h06);
    send_bit(1'b1, 1'b0);
    send_bit(1'b1, 1'b1);
    repeat (3) @(posedge clock);
    #1 chk(ready, 1'b0, "ready while pair pending");
    send_bit(1'b0, 1'b1);
    repeat (60) @(posedge clock);
    chk(16'(chips.size()), 16'd5, "chip count");
    chk({chips[0], chips[1], chips[2], chips[3], chips[4]}, 5'b11001, "manchester chips");
    chk(16'(ctime[2] - ctime[1]), 16'd4, "chip period");
    chk(16'(ctime[4] - ctime[3]), 16'd4, "chip period");
    chips.delete();
    wr_reg(OFS_MODE, 8'h02);
    send_bit(1'b1, 1'b1);
    repeat (12) @(posedge clock);
    chk(16'(chips.size()), 16'd1, "no pair outside packet mode");
    $display("manchester transmit done");
  endtask

  task automatic t_tx_white();
    int i;
    chips.delete();
    wr_reg(OFS_PAYLOAD_CFG, 8'h00);
    wr_reg(OFS_PACKET_CFG, 8'h10);
    wr_reg(OFS_RATE_CFG, 8'h00);
    send_bit(1'b1, 1'b0);
    for (i = 0; i < 12; i++) send_bit(1'b0, 1'b1);
    @(posedge clock) txp <= 1'b0;
    repeat (10) @(posedge clock);
    chk(16'(chips.size()), 16'd13, "one chip per bit");
    for (i = 0; i < 12; i++) got[11 - i] = chips[i + 1];
    chk(chips[0], 1'b1, "plain header");
    chk(got, wseq(), "whitened chips");
    $display("whitening transmit done");
  endtask

  task automatic t_rx();
    int i;
    wr_reg(OFS_PAYLOAD_CFG, 8'h80);
    wr_reg(OFS_PACKET_CFG, 8'h00);
    wr_reg(OFS_MODE, 8'h05);
    pulse_src(11'h008);
    rd_reg(OFS_LINE_STATUS);
    chk(d[2], 1'b1, "payload window open");
    feed(16'h9C00, 5'd6);
    chk({rbits[0], rbits[1]}, 2'b10, "manchester decode");
    rd_reg(OFS_IRQ_STATUS);
    chk(d[IRQ_DECERR], 1'b1, "pair error");
    @(posedge clock) fend <= 1'b1;
    @(posedge clock) fend <= 1'b0;
    rbits.delete();
    feed(16'h9000, 5'd4);
    chk(16'(rbits.size()), 16'd0, "chips outside frame");
    wr_reg(OFS_PAYLOAD_CFG, 8'h00);
    wr_reg(OFS_PACKET_CFG, 8'h10);
    pulse_src(11'h008);
    feed({wseq(), 4'h0}, 5'd12);
    for (i = 0; i < 12; i++) got[11 - i] = rbits[i];
    chk(got, 12'h000, "dewhitened bits");
    @(posedge clock) fend <= 1'b1;
    @(posedge clock) fend <= 1'b0;
    $display("receive done");
  endtask

  task automatic t_irq();
    wr_reg(OFS_IRQ_CLEAR, 8'hFF);
    wr_reg(OFS_IRQ_ENABLE, 8'h00);
    pulse_src(11'h008);
    rd_reg(OFS_IRQ_STATUS);
    chk(d, 8'h01, "sync status");
    chk(irq, 1'b0, "masked interrupt");
    wr_reg(OFS_IRQ_ENABLE, 8'h01);
    #1 chk(irq, 1'b1, "enabled interrupt");
    wr_reg(OFS_IRQ_CLEAR, 8'h01);
    rd_reg(OFS_IRQ_STATUS);
    chk({d, irq}, 9'h000, "cleared interrupt");
    $display("interrupt done");
  endtask

  task automatic t_events();
    logic [2:0] md [19] = '{5, 5, 5, 5, 5, 5, 5, 5, 4, 4, 4, 4, 4, 6, 6, 6, 6, 5, 5};
    logic [5:0] rt [19] = '{0, 1, 2, 3, 0, 4, 8, 12, 0, 2, 4, 12, 8, 0, 32, 0, 16, 3, 3};
    logic [3:0] ix [19] = '{0, 1, 2, 3, 5, 6, 7, 8, 0, 2, 6, 8, 7, 9, 2, 6, 10, 4, 3};
    logic [1:0] ab [19] = '{2, 2, 2, 2, 1, 1, 1, 1, 0, 2, 1, 1, 0, 2, 2, 1, 1, 2, 0};
    int         i;
    for (i = 0; i < 19; i++) begin
      wr_reg(OFS_PACKET_CFG, (i > 16) ? 8'h02 : 8'h00);
      wr_reg(OFS_MODE, {5'h00, md[i]});
      wr_reg(OFS_EVENT_ROUTE, {2'b00, rt[i]});
      @(posedge clock) src <= 11'h001 << ix[i];
      @(posedge clock) src <= src & ~11'h039;
      repeat (3) @(posedge clock);
      #1 chk({ea, eb}, ab[i], "event routing");
      pulse_src(11'h004);
      repeat (3) @(posedge clock);
      #1 chk({ea, eb}, 2'b00, "hold released");
    end
    $display("event lines done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_tx_man();
    t_tx_white();
    t_rx();
    t_irq();
    t_events();
    report_and_stop();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
